// >>> ctd_pkg.sv
// Package: constants for the cable type detect block
package ctd_pkg;
  localparam int unsigned CTD_CLK_MHZ       = 125;
  // Drive-low time, microseconds (least)
  localparam int unsigned CTD_DRIVE_US      = 30;
  // Sample window after release, microseconds
  localparam int unsigned CTD_SAMP_MIN_US   = 2;
  localparam int unsigned CTD_SAMP_MAX_US   = 13;
  localparam int unsigned CTD_DRIVE_CYC     = CTD_DRIVE_US * CTD_CLK_MHZ;
  localparam int unsigned CTD_SAMP_MIN_CYC  = CTD_SAMP_MIN_US * CTD_CLK_MHZ;
  localparam int unsigned CTD_SAMP_MAX_CYC  = CTD_SAMP_MAX_US * CTD_CLK_MHZ;
  localparam int unsigned CTD_CNT_W         = 13;
  // Cable bit position within identify word 93
  localparam int unsigned CTD_ID_WORD       = 93;
  localparam int unsigned CTD_CABLE_BIT     = 13;
  localparam logic        CTD_RST_CABLE     = 1'b0;
  typedef logic [CTD_CNT_W-1:0] ctd_cnt_t;
endpackage

// >>> ctd_tmr_if.sv
// Interface: timer control between detect sequencer and its counter
`timescale 1ns/1ps
interface ctd_tmr_if;
  logic     clr;
  logic     run;
  ctd_pkg::ctd_cnt_t cnt;
  modport ctl (output clr, output run, input cnt);
  modport tmr (input clr, input run, output cnt);
endinterface

// >>> ctd_timer.sv
// Saturating cycle counter used for drive and sample timing
`timescale 1ns/1ps
module ctd_timer (
  // Clock, reset and enable
  input  wire logic  i_clk_sys,
  input  wire logic  i_rst_b,
  input  wire logic  i_ce,
  // Control
  ctd_tmr_if.tmr     tmr
);
  import ctd_pkg::*;
  ctd_cnt_t cnt_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      if (tmr.clr) begin
        cnt_q <= '0;
      end else if (tmr.run && cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
  assign tmr.cnt = cnt_q;
endmodule

// >>> ctd_detect.sv
// Top: device-side cable type detection on the shared diag line
//
// Notes on behaviour
// R01 - Host keeps Ultra DMA at mode 2 or below without 80-wire cable.
// R02 - On identify, drive line low, release it, then sample it.
// R03 - Host sends identify to Device 1 first, then Device 0.
// R04 - Device 1 stops driving the line once it receives identify; here it drops its diag drive but still runs its own drive-low test.
// R05 - Line held low at least 30 us before identify data moves.
// R06 - Sample taken between 2 and 13 us after release.
// R07 - Low sample reports zero in word 93 bit 13 (40-wire).
// R08 - High sample reports one in word 93 bit 13 (80-wire).
// R09 - Host merges own abilities with words 88 and 93.
// R10 - Host then programs the chosen mode by set features.
// R11 - Hosts should sense the line themselves instead.
// R12 - Device times with own clock and syncs line in two stages.

`timescale 1ns/1ps
module ctd_detect
  import ctd_pkg::*;
#(
  parameter int unsigned DRIVE_CYC = ctd_pkg::CTD_DRIVE_CYC,
  // Line is read SAMP_CYC-2 cycles after release (two sync stages);
  // the extra cycle keeps that read just past the window's early end
  parameter int unsigned SAMP_CYC  = ctd_pkg::CTD_SAMP_MIN_CYC + 3
) (
  // Clock, reset, enable
  input  wire logic i_clk_sys,
  input  wire logic i_rst_b,
  input  wire logic i_ce,
  // Command side
  input  wire logic i_identify,
  input  wire logic i_is_dev1,
  input  wire logic i_diag_drive,
  // Cable identification line (open drain)
  input  wire logic i_cable_id_line,
  output logic      o_cable_id_line,
  output logic      o_cable_id_line_oe,
  // Results
  output logic      o_busy,
  output logic      o_done,
  output logic      o_cable_80
);
  import ctd_pkg::*;

  // Sequence in enabled cycles, counted from the take edge:
  //   take  - pull low, raise busy, clear the timer
  //   DRIVE - pull held DRIVE_CYC cycles, then released
  //   WAIT  - SAMP_CYC cycles, then the synced line is latched
  // Identify seen while busy is dropped; the host waits on busy.
  typedef enum logic [1:0] {
    CTD_IDLE,
    CTD_DRIVE,
    CTD_WAIT
  } ctd_state_e;

  // Last count of each phase; the timer clears on entry to DRIVE and to WAIT
  // The counter type must hold DRIVE_CYC; widen it for slower windows
  localparam ctd_cnt_t DRIVE_END = ctd_cnt_t'(DRIVE_CYC - 1);
  localparam ctd_cnt_t SAMP_END  = ctd_cnt_t'(SAMP_CYC - 1);

  // Sequencer, synchroniser and release latch
  ctd_state_e state_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       released_q;
  ctd_tmr_if  tmr ();

  // Decoded strobes shared by sequencer, line and results
  logic       take_cmd;
  logic       drive_last;
  logic       samp_last;
  logic       dev1_cmd;
  logic       diag_ok;
  logic       pull_low;

  // Shared phase timer; saturates rather than wrapping on a stall
  ctd_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_ce      (i_ce),
    .tmr       (tmr)
  );

  // R12 two-stage sync
  // Reset to the idle high level so no false low follows reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else if (i_ce) begin
      sync1_q <= i_cable_id_line;
      sync2_q <= sync1_q;
    end
  end

  // Command decode; identify starts a test only in idle, but the Device 1 release takes it in any state
  always_comb begin
    take_cmd = (state_q == CTD_IDLE) && i_identify;
    dev1_cmd = i_identify && i_is_dev1;
  end

  // Phase ends, decoded once so all registers agree on the cycle
  always_comb begin
    drive_last = (state_q == CTD_DRIVE) && (tmr.cnt == DRIVE_END);
    samp_last  = (state_q == CTD_WAIT) && (tmr.cnt == SAMP_END);
  end

  // R04 Device 1 mask
  // Offered only while idle, so it can never spoil a sample
  always_comb begin
    diag_ok = i_diag_drive && !released_q && !dev1_cmd &&
              (state_q == CTD_IDLE);
  end

  // R05 pull low window
  always_comb begin
    pull_low = take_cmd ||
               ((state_q == CTD_DRIVE) && !drive_last) ||
               diag_ok;
  end

  // Timer clears while idle and at release, so WAIT counts from zero
  always_comb begin
    tmr.clr = (state_q == CTD_IDLE) || drive_last;
    tmr.run = (state_q != CTD_IDLE);
  end

  // R02 detect sequence
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= CTD_IDLE;
    end else if (i_ce) begin
      case (state_q)
        CTD_IDLE: begin
          if (take_cmd) begin
            state_q <= CTD_DRIVE;
          end
        end
        // R05 hold low 30 us
        CTD_DRIVE: begin
          if (drive_last) begin
            state_q <= CTD_WAIT;
          end
        end
        // R06 sample in window
        CTD_WAIT: begin
          if (samp_last) begin
            state_q <= CTD_IDLE;
          end
        end
        // Unused code falls back to idle
        default: begin
          state_q <= CTD_IDLE;
        end
      endcase
    end
  end

  // R04 Device 1 release after identify
  // Sticky to reset: the host repeats the order only after a reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      released_q <= 1'b0;
    end else if (i_ce && dev1_cmd) begin
      released_q <= 1'b1;
    end
  end

  // R02 open drain value
  // Value is fixed low; the pull-up lives outside this block
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cable_id_line <= 1'b0;
    end else if (i_ce) begin
      o_cable_id_line <= 1'b0;
    end
  end

  // R05 registered pull
  // Registered so the pin never glitches on decode
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cable_id_line_oe <= 1'b0;
    end else if (i_ce) begin
      o_cable_id_line_oe <= pull_low;
    end
  end

  // R06 result strobe
  // One pulse, on the same edge as the new result bit
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= samp_last;
    end
  end

  // R05 busy holds identify data
  // Busy spans the whole test so no identify word leaves early
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= take_cmd ||
                (state_q == CTD_DRIVE) ||
                ((state_q == CTD_WAIT) && !samp_last);
    end
  end

  // R07 R08 capture result bit
  // Taken from the second sync stage, so the line is two cycles old
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cable_80 <= CTD_RST_CABLE;
    end else if (i_ce) begin
      if (samp_last) begin
        o_cable_80 <= sync2_q;
      end
    end
  end
endmodule

// >>> ctd_detect_asserts.sv
// Port checker for cable type detect
`timescale 1ns/1ps
module ctd_detect_chk #(
  parameter int DRIVE_CYC = 20,
  parameter int SAMP_CYC  = 8
) (
  input wire logic i_clk_sys, i_rst_b, i_ce, i_identify, i_is_dev1,
  input wire logic i_diag_drive, i_cable_id_line, o_cable_id_line,
  input wire logic o_cable_id_line_oe, o_busy, o_done, o_cable_80
);
  localparam int DL = DRIVE_CYC - 1;
  localparam int TD = DRIVE_CYC + SAMP_CYC;
  logic rel_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b) rel_q <= 1'b0;
    else if (i_ce && i_identify && i_is_dev1 && !o_busy) rel_q <= 1'b1;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  start_drv_a: assert property (
    i_ce && i_identify && !o_busy |=> o_busy && o_cable_id_line_oe)
    else $error("no drive");
  hold_low_a: assert property (
    $rose(o_busy) && !i_diag_drive |-> o_cable_id_line_oe ##DL
    o_cable_id_line_oe ##1 !o_cable_id_line_oe) else $error("low time");
  done_time_a: assert property (
    $rose(o_busy) |-> ##TD o_done && !o_busy) else $error("done time");
  result_a: assert property (
    o_done |-> o_cable_80 == $past(i_cable_id_line, 3)) else $error("bit");
  keep_res_a: assert property (
    !o_done |-> $stable(o_cable_80)) else $error("bit moved");
  dev1_rel_a: assert property (
    rel_q && !o_busy |-> !o_cable_id_line_oe) else $error("not released");
  od_zero_a: assert property (
    o_cable_id_line_oe |-> !o_cable_id_line) else $error("drives high");
  cover property (o_done && o_cable_80);
  cover property (o_done && !o_cable_80);
  cover property (rel_q && o_done);
endmodule
bind ctd_detect ctd_detect_chk #(.DRIVE_CYC(DRIVE_CYC), .SAMP_CYC(SAMP_CYC))
  chk_u (.*);

// >>> ctd_line_model.sv
// Far side of the cable id line: pull-up, host capacitor, Device 1
`timescale 1ns/1ps
module ctd_line_model (
  input  wire logic i_clk_sys,
  input  wire logic i_oe,
  input  wire logic i_cap,
  input  wire logic i_hog,
  output logic      o_line
);
  // Starts settled, so the line reads high before any pull
  logic [5:0] rise_q = 6'h3F;
  always_ff @(posedge i_clk_sys)
    if (i_oe) rise_q <= 6'h00;
    else if (rise_q != 6'h3F) rise_q <= rise_q + 6'h01;
  assign o_line = !(i_oe || i_hog || (i_cap && rise_q < 6'h28));
endmodule

// >>> tb_top.sv
// Self-checking bench for cable type detect
`timescale 1ns/1ps
module tb_top;
  logic i_clk_sys, i_rst_b, i_ce, i_identify, i_is_dev1, i_diag_drive;
  logic i_cable_id_line, o_cable_id_line, o_cable_id_line_oe;
  logic o_busy, o_done, o_cable_80, cap, hog;
  int   err_count = 0;
  int   compares = 0;
  logic exp_q[$];
  ctd_detect #(.DRIVE_CYC(20), .SAMP_CYC(8)) dut_u (.*);
  ctd_line_model line_u (.i_clk_sys(i_clk_sys), .i_oe(o_cable_id_line_oe),
    .i_cap(cap), .i_hog(hog), .o_line(i_cable_id_line));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic s, input logic e, input string n);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %b seen %b", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A second identify lands mid-detect; it must bring no extra result
  task automatic detect(input logic d, input logic c, input logic h);
    logic [2:0] w88;
    logic [2:0] udma;
    i_is_dev1 = d;
    cap = c;
    hog = h;
    i_identify = 1'b1;
    exp_q.push_back(!(c || h));
    @(negedge i_clk_sys) i_identify = 1'b0;
    repeat (9) @(negedge i_clk_sys);
    i_identify = 1'b1;
    @(negedge i_clk_sys) i_identify = 1'b0;
    repeat (30) @(negedge i_clk_sys);
    // word 88 top mode, drawn at random from 0 to 5
    w88 = 3'($urandom_range(5));
    // mode to be set, capped at 2 on 40-wire
    udma = (o_cable_80 === 1'b1) ? w88 : ((w88 > 3'h2) ? 3'h2 : w88);
    check(udma > 3'h2, w88 > 3'h2 && !(c || h), "fast mode");
    $display("test end dev1 %b cap %b hog %b", d, c, h);
  endtask
  always @(negedge i_clk_sys)
    if (o_done === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0, "spare done");
      else check(o_cable_80, exp_q.pop_front(), "cable bit");
    end
  initial begin
    {i_rst_b, i_identify, i_is_dev1, i_diag_drive, cap, hog} = 6'h00;
    i_ce = 1'b1;
    void'($urandom(20));
    repeat (2) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    i_diag_drive = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check(o_cable_id_line_oe, 1'b1, "diag drive");
    detect(1'b1, 1'b0, 1'b0);
    check(o_cable_id_line_oe, 1'b0, "dev1 release");
    check(i_cable_id_line, 1'b1, "host sense");
    i_diag_drive = 1'b0;
    detect(1'b0, 1'b0, 1'b1);
    detect(1'b0, 1'b1, 1'b0);
    repeat (6) detect(1'b0, 1'($urandom_range(1)), 1'b0);
    i_ce = 1'b0;
    i_identify = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    {i_ce, i_identify} = 2'b10;
    repeat (2) @(negedge i_clk_sys);
    check(o_busy, 1'b0, "frozen take");
    $display("test end clock enable low");
    check(exp_q.size() == 0, 1'b1, "all done");
    tally_and_finish();
  end
  // Roughly six and a half times the expected run
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
endmodule
